//--- src/card_mirror_defs.vh
/*
 Register offsets, field positions and reset values for the card
 configuration mirror block. Assumes inclusion by bare name.
*/
`ifndef CARD_MIRROR_DEFS_VH
`define CARD_MIRROR_DEFS_VH

// Register indices; the bus byte address is four times the index
`define OFF_CFG_STATUS 8'h00_E1
`define OFF_PIN_REPL 8'h00_E2
`define OFF_SOCKET_COPY 8'h00_E3
`define OFF_EVENT_STATUS 8'h00_E4
`define OFF_EVENT_ENABLE 8'h00_E5
`define OFF_MISC 8'h00_E6
`define OFF_GROUP_CTRL 8'h00_53
`define OFF_GROUP_ACTIVE 8'h00_52

// Host-side register selects (host address bits)
`define HOST_CFG_OPTION 10'h0_200
`define HOST_CFG_STATUS 10'h0_202
`define HOST_PIN_REPL 10'h0_204
`define HOST_SOCKET_COPY 10'h0_206
`define HOST_CIS_LAST 10'h0_1FF

// Access mode index codes
`define MODE_MEMORY 4'h0
`define MODE_BLOCK_IO 4'h1
`define MODE_PRIMARY_IO 4'h2
`define MODE_SECONDARY_IO 4'h3
`define MODE_PRIMARY_FLOPPY 4'h4
`define MODE_SECONDARY_FLOPPY 4'h5

// Interface choice codes
`define SEL_AUTO 2'h0
`define SEL_ATA 2'h1
`define SEL_CARD 2'h2

// Field positions
`define BIT_SUMMARY 7
`define BIT_PIN_ENABLE 6
`define BIT_SLEEP 2
`define BIT_READY_DELTA 5
`define BIT_READY_LEVEL 1
`define BIT_GROUP_ENABLE 2

// Reset values
`define RST_BYTE 8'h00
`define PIN_REPL_RESET 8'h0C
`endif

//--- src/sticky_event_bit.v
/*
 One sticky event flag with write-one-to-clear.
 Assumes the set and clear strobes are single-cycle and synchronous.
*/
`timescale 1ns/1ps
module sticky_event_bit
(
   // Clock and reset
   input wire clock,
   input wire resetn,
   // Strobes
   input wire set_pulse,
   input wire clear_pulse,
   // State
   output reg flag
);

   // Set wins over a simultaneous clear
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         flag <= 1'b0;
      else if (set_pulse)
         flag <= 1'b1;
      else if (clear_pulse)
         flag <= 1'b0;
   end
endmodule

//--- src/host_cfg_regs.v
/*
 Host-written configuration registers: option, status, pin image and
 socket/copy, with the write and read strobes that raise events.
 Assumes host strobes are one-cycle pulses synchronous to clock.
*/
`timescale 1ns/1ps
`include "card_mirror_defs.vh"
module host_cfg_regs
(
   // Clock and reset
   input wire clock,
   input wire resetn,
   // Host access
   input wire host_write,
   input wire host_read_attr,
   input wire [9:0] host_addr,
   input wire [7:0] host_wdata,
   // Internal readiness
   input wire readiness_level,
   // Stored images
   output reg [7:0] option_image,
   output reg [7:0] status_image,
   output reg readiness_delta,
   output reg [7:0] socket_image,
   // Event strobes, bits 5..0 of the event group
   output wire [5:0] event_pulse
);

   wire wr_opt;
   wire wr_stat;
   wire wr_pin;
   wire wr_sock;
   wire sleep_change;
   reg ready_prev;
   reg ready_seen;

   assign wr_opt = host_write && (host_addr == `HOST_CFG_OPTION);
   assign wr_stat = host_write && (host_addr == `HOST_CFG_STATUS);
   assign wr_pin = host_write && (host_addr == `HOST_PIN_REPL);
   assign wr_sock = host_write && (host_addr == `HOST_SOCKET_COPY);
   assign sleep_change = wr_stat &&
      (host_wdata[`BIT_SLEEP] != status_image[`BIT_SLEEP]);

   // Event strobes in status-bit order
   assign event_pulse = {host_read_attr && (host_addr <= `HOST_CIS_LAST),
      wr_sock, sleep_change, wr_pin, wr_stat, wr_opt};

   // Host-written images and readiness change tracking
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         option_image <= `RST_BYTE; // memory mode at power-on
         status_image <= `RST_BYTE;
         socket_image <= `RST_BYTE;
         readiness_delta <= 1'b0;
         ready_prev <= 1'b0;
         ready_seen <= 1'b0;
      end
      else
      begin
         // First cycle after reset only primes the previous level, no false edge
         ready_seen <= 1'b1;
         ready_prev <= readiness_level;
         if (wr_opt)
            option_image <= host_wdata;
         if (wr_stat)
            status_image <= host_wdata;
         if (wr_sock)
            socket_image <= host_wdata;
         if (ready_seen && (ready_prev != readiness_level))
            readiness_delta <= 1'b1;
         else if (wr_pin && host_wdata[`BIT_READY_LEVEL])
            readiness_delta <= host_wdata[`BIT_READY_DELTA];
      end
   end
endmodule

//--- src/card_config_mirror_and_host_events.v
/*
 Local-processor view of the card configuration registers, host event
 flags and the host interface miscellaneous register, on AHB-Lite.
 Assumes host access strobes, readiness, interrupt and reset inputs are
 synchronous to clock; the strap is stable around reset release.
*/
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "card_mirror_defs.vh"

// Operation
// - Codes 4,5 floppy I/O; 6-15 reserved
// - Code 0 memory default; 1-3 I/O modes
// - Summary bit is OR of change bits
// - Enabled summary drives status pin in I/O
// - Interrupt view gated by mode and enable
// - E1h mirrors host status register
// - Unused pin bits read fixed values
// - Readiness change sets readiness delta
// - Host one to level writes delta
// - Socket/copy mirror shows copy and socket
// - Event bits sticky until write-one clear
// - Attribute read 000h-1FFh sets bit 5
// - Host register writes set event bits
// - Sleep bit change sets bit 3
// - Enable and group enable gate active flag
// - Misc bit 7 shows live host reset
// - Misc bit 6 shows active interface
// - Select field: auto, ATA, card, reserved
// - Auto picks ATA unless strap pulled down
// - Scratch bits mirrored unchanged
module card_config_mirror_and_host_events
(
   // Clock and reset
   input wire clock,
   input wire resetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // Host side of the card interface
   input wire host_write,
   input wire host_read_attr,
   input wire [9:0] host_addr,
   input wire [7:0] host_wdata,
   input wire host_reset,
   input wire host_irq_gate_n,
   input wire ata_irq_request,
   input wire readiness_level,
   input wire mode_strap_pin,
   output reg status_event_pin_n,
   // Decoded state to the rest of the chip
   output wire [3:0] access_mode_index,
   output wire io_mode,
   output wire floppy_support,
   output wire active_interface_flag,
   output wire host_event_active
);

   wire [7:0] option_image;
   wire [7:0] status_image;
   wire readiness_delta;
   wire [7:0] socket_image;
   wire [5:0] event_pulse;
   wire [5:0] event_flag;
   wire [7:0] cfg_status_view;
   wire [7:0] pin_view;
   wire summary;
   wire ata_irq_view;
   wire bus_write;
   wire bus_read;
   // Named views of register fields
   wire summary_pin_enable;
   wire host_narrow_only;
   wire host_sleep_request;
   wire [2:0] host_scratch_bits;
   wire [2:0] copy_number;
   wire [3:0] socket_number;
   wire [7:0] misc_view;
   wire [7:0] group_ctrl_view;
   wire [7:0] group_active_view;
   reg [5:0] event_enable;
   reg host_event_group_enable;
   reg [1:0] interface_choice;
   reg strap_ata;
   reg strap_taken;
   reg wr_pending;
   reg [7:0] wr_addr;
   reg [5:0] clear_pulse;
   // Combinational decode results
   reg mode_io;
   reg mode_floppy;
   reg mode_irq;
   reg iface_ata;
   reg [31:0] next_hrdata;

   // Host-written images and event strobes
   host_cfg_regs u_host_regs
   (
      .clock(clock),
      .resetn(resetn),
      .host_write(host_write),
      .host_read_attr(host_read_attr),
      .host_addr(host_addr),
      .host_wdata(host_wdata),
      .readiness_level(readiness_level),
      .option_image(option_image),
      .status_image(status_image),
      .readiness_delta(readiness_delta),
      .socket_image(socket_image),
      .event_pulse(event_pulse)
   );

   // One sticky flag per event
   genvar i;
   generate
      for (i = 0; i < 6; i = i + 1)
      begin : g_event
         sticky_event_bit u_flag
         (
            .clock(clock),
            .resetn(resetn),
            .set_pulse(event_pulse[i]),
            .clear_pulse(clear_pulse[i]),
            .flag(event_flag[i])
         );
      end
   endgenerate

   // Access mode decode from the index
   assign access_mode_index = option_image[3:0];

   // Mode classes; codes 6 and up are reserved and act as no I/O
   always @*
   begin
      mode_io = 1'b0;
      mode_floppy = 1'b0;
      mode_irq = 1'b0;
      case (access_mode_index)
         `MODE_MEMORY:
            mode_io = 1'b0; // power-on default
         `MODE_BLOCK_IO:
            mode_io = 1'b1;
         `MODE_PRIMARY_IO, `MODE_SECONDARY_IO:
         begin
            mode_io = 1'b1;
            mode_irq = 1'b1; // interrupt view allowed
         end
         `MODE_PRIMARY_FLOPPY, `MODE_SECONDARY_FLOPPY:
         begin
            mode_io = 1'b1;
            mode_floppy = 1'b1;
            mode_irq = 1'b1;
         end
         default:
         begin
            mode_io = 1'b0; // reserved codes
            mode_floppy = 1'b0;
            mode_irq = 1'b0;
         end
      endcase
   end

   // Decoded mode outputs
   assign io_mode = mode_io;
   assign floppy_support = mode_floppy;

   // Interrupt view only in the I/O modes that carry it, with gate enabled
   assign ata_irq_view = ata_irq_request && !host_irq_gate_n && mode_irq;

   // Pin image: fixed battery and lock bits, live readiness
   assign pin_view = {1'b0, 1'b0, readiness_delta, 1'b0,
      1'b1, 1'b1, readiness_level, 1'b0};
   assign summary = |pin_view[7:4];

   // Named fields of the host-written status image
   assign summary_pin_enable = status_image[`BIT_PIN_ENABLE];
   assign host_narrow_only = status_image[5];
   assign host_sleep_request = status_image[`BIT_SLEEP];
   assign host_scratch_bits = {status_image[4:3], status_image[0]};

   // Status mirror: host bits with summary and interrupt view
   assign cfg_status_view = {summary, summary_pin_enable, host_narrow_only,
      host_scratch_bits[2:1], host_sleep_request, ata_irq_view,
      host_scratch_bits[0]};

   // Status-change pin, high unless the enabled summary is set in I/O mode
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         status_event_pin_n <= 1'b1;
      else
         status_event_pin_n <= !(summary_pin_enable && io_mode && summary);
   end

   // Group active flag
   assign host_event_active = host_event_group_enable &&
      |(event_flag & event_enable);

   // Strap captured once after reset release; pulled low selects card mode
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         strap_ata <= 1'b1;
         strap_taken <= 1'b0;
      end
      else if (!strap_taken)
      begin
         strap_ata <= mode_strap_pin;
         strap_taken <= 1'b1;
      end
   end

   // Active interface: forced choice overrides the automatic strap choice
   always @*
   begin
      iface_ata = strap_ata;
      case (interface_choice)
         `SEL_ATA:
            iface_ata = 1'b1; // forced ATA
         `SEL_CARD:
            iface_ata = 1'b0; // forced card mode
         `SEL_AUTO:
            iface_ata = strap_ata;
         default:
            iface_ata = strap_ata; // reserved code behaves as automatic
      endcase
   end
   assign active_interface_flag = iface_ata;

   // AHB-Lite: zero wait, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign bus_write = hsel && hready && htrans[1] && hwrite;
   assign bus_read = hsel && hready && htrans[1] && !hwrite;

   // Address phase capture for writes
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_pending <= 1'b0;
         wr_addr <= `RST_BYTE;
      end
      else if (hready)
      begin
         wr_pending <= bus_write;
         wr_addr <= haddr[9:2]; // word index of the register
      end
   end

   // Data phase: writable registers and clear strobes
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         event_enable <= 6'h00;
         host_event_group_enable <= 1'b0;
         interface_choice <= `SEL_AUTO;
         clear_pulse <= 6'h00;
      end
      else
      begin
         clear_pulse <= 6'h00;
         if (wr_pending)
         begin
            case (wr_addr)
               `OFF_EVENT_STATUS:
                  clear_pulse <= hwdata[5:0];
               `OFF_EVENT_ENABLE:
                  event_enable <= hwdata[5:0];
               `OFF_MISC:
                  interface_choice <= hwdata[1:0];
               `OFF_GROUP_CTRL:
                  host_event_group_enable <= hwdata[`BIT_GROUP_ENABLE];
               `OFF_CFG_STATUS, `OFF_PIN_REPL, `OFF_SOCKET_COPY, `OFF_GROUP_ACTIVE:
                  clear_pulse <= 6'h00; // read-only images ignore writes
               default:
                  clear_pulse <= 6'h00;
            endcase
         end
      end
   end

   // Field views for the remaining read-back registers
   assign copy_number = socket_image[6:4];
   assign socket_number = socket_image[3:0];
   assign misc_view = {host_reset, active_interface_flag, 4'h0, interface_choice};
   assign group_ctrl_view = {5'h00, host_event_group_enable, 2'h0};
   assign group_active_view = {5'h00, host_event_active, 2'h0};

   // Read mux by register index; reserved bits and unmapped indices read zero
   always @*
   begin
      next_hrdata = 32'h0000_0000;
      case (haddr[9:2])
         `OFF_CFG_STATUS:
            next_hrdata = {24'h00_0000, cfg_status_view};
         `OFF_PIN_REPL:
            next_hrdata = {24'h00_0000, pin_view};
         `OFF_SOCKET_COPY:
            next_hrdata = {25'h000_0000, copy_number, socket_number};
         `OFF_EVENT_STATUS:
            next_hrdata = {26'h000_0000, event_flag};
         `OFF_EVENT_ENABLE:
            next_hrdata = {26'h000_0000, event_enable};
         `OFF_MISC:
            next_hrdata = {24'h00_0000, misc_view};
         `OFF_GROUP_CTRL:
            next_hrdata = {24'h00_0000, group_ctrl_view};
         `OFF_GROUP_ACTIVE:
            next_hrdata = {24'h00_0000, group_active_view};
         default:
            next_hrdata = 32'h0000_0000;
      endcase
   end

   // Read data, registered in the address phase, standing until the next read
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         hrdata <= 32'h0000_0000;
      else if (bus_read)
         hrdata <= next_hrdata;
   end
endmodule

//--- tb/card_mirror_asserts.sv
/* Checker for the card mirror block.
   Assumes it is bound onto the top module, one clock domain. */
`timescale 1ns/1ps
module card_mirror_asserts
(
   // Clock and reset
   input wire clock,
   input wire resetn,
   // Inputs watched
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire host_write,
   input wire host_read_attr,
   input wire [9:0] host_addr,
   input wire [7:0] host_wdata,
   // Outputs watched
   input wire status_event_pin_n,
   input wire [3:0] access_mode_index,
   input wire io_mode,
   input wire floppy_support,
   input wire active_interface_flag,
   input wire host_event_active
);
   logic [3:0] since_wr;
   logic [3:0] since_host;
   logic [3:0] since_rst;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // Saturating ages of the last bus write, host access and reset release
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         since_wr <= 4'hF;
         since_host <= 4'hF;
         since_rst <= 4'h0;
      end
      else
      begin
         since_wr <= (since_wr == 4'hF) ? 4'hF : since_wr + 4'h1;
         since_host <= (since_host == 4'hF) ? 4'hF : since_host + 4'h1;
         since_rst <= (since_rst == 4'hF) ? 4'hF : since_rst + 4'h1;
         if (hsel && hready && htrans[1] && hwrite)
            since_wr <= 4'h0;
         if (host_write || host_read_attr)
            since_host <= 4'h0;
      end
   end
   AST_MODE_DECODE: assert property (
      io_mode == (access_mode_index inside {[4'h1:4'h5]})
      && floppy_support == (access_mode_index inside {4'h4, 4'h5})) else $error("decode");
   AST_OPTION_LOAD: assert property (
      host_write && host_addr == 10'h200 |=> access_mode_index == $past(host_wdata[3:0]))
      else $error("option load");
   AST_OPTION_HOLD: assert property (
      $changed(access_mode_index) |-> $past(host_write) && $past(host_addr) == 10'h200)
      else $error("option drift");
   AST_PIN_IDLE: assert property (!io_mode |=> status_event_pin_n)
      else $error("pin low outside io");
   AST_PIN_CAUSE: assert property ($fell(status_event_pin_n) |-> $past(io_mode))
      else $error("pin fell");
   AST_ACTIVE_RISE: assert property (
      $rose(host_event_active) |-> since_host < 4'h3 || since_wr < 4'h5) else $error("rise");
   AST_ACTIVE_FALL: assert property (
      $fell(host_event_active) |-> since_wr < 4'h5) else $error("flag lost");
   AST_IFACE_HOLD: assert property (
      $changed(active_interface_flag) |-> since_wr < 4'h5 || since_rst < 4'h3)
      else $error("iface drift");
   cover property (!status_event_pin_n);
   cover property ($fell(host_event_active));
   cover property (floppy_support);
endmodule

//--- tb/host_adapter_model.sv
/* Host adapter model: one-cycle host writes and attribute reads.
   Assumes calls start just after a rising clock edge. */
`timescale 1ns/1ps
module host_adapter_model
(
   // Clock
   input wire logic clock,
   // Host access
   output logic host_write,
   output logic host_read_attr,
   output logic [9:0] host_addr,
   output logic [7:0] host_wdata
);
   // Idle strobes low
   initial
   begin
      host_write = 1'b0;
      host_read_attr = 1'b0;
      host_addr = 10'h000;
      host_wdata = 8'h00;
   end
   // Sleep, narrow and scratch bits travel in the written byte
   task automatic access(input logic rd, input logic [9:0] a, input logic [7:0] d);
      host_write <= !rd;
      host_read_attr <= rd;
      host_addr <= a;
      host_wdata <= d;
      @(posedge clock);
      host_write <= 1'b0;
      host_read_attr <= 1'b0;
      host_addr <= ~a; // Released bus never shows stale values
      host_wdata <= ~d;
      repeat (2) @(posedge clock);
   endtask
endmodule

//--- tb/card_config_mirror_and_host_events_tb.sv
/* Bench for the card mirror block over AHB-Lite.
   Assumes zero-wait answers and one clock. */
`timescale 1ns/1ps
module card_config_mirror_and_host_events_tb;
   logic clock, resetn, hsel, hwrite, host_reset, host_irq_gate_n, ata_irq_request;
   logic readiness_level, mode_strap_pin, status_event_pin_n, io_mode, floppy_support;
   logic active_interface_flag, host_event_active, hreadyout, hresp, host_write, host_read_attr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [9:0] host_addr;
   logic [7:0] host_wdata, q;
   logic [3:0] access_mode_index;
   int miscompares, checks;
   card_config_mirror_and_host_events DUT (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .host_write,
      .host_read_attr, .host_addr, .host_wdata, .host_reset, .host_irq_gate_n,
      .ata_irq_request, .readiness_level, .mode_strap_pin, .status_event_pin_n,
      .access_mode_index, .io_mode, .floppy_support, .active_interface_flag,
      .host_event_active);
   host_adapter_model host (.clock, .host_write, .host_read_attr, .host_addr, .host_wdata);
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic summarize;
      if (miscompares == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // One single-word transfer; read data lands in q
   task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h00_0000, a, 2'b00}; // register index to byte address
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      q = hrdata[7:0];
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      ahb(1'b0, a, 8'h00);
      check(q, exp);
   endtask
   // Strap default, choice overrides, live host reset
   task automatic t_misc;
      rd(8'hE6, 8'h00);
      rd(8'h70, 8'h00);
      host_reset <= 1'b1;
      ahb(1'b1, 8'hE6, 8'h01);
      rd(8'hE6, 8'hC1);
      ahb(1'b1, 8'hE6, 8'h02);
      rd(8'hE6, 8'h82);
      ahb(1'b1, 8'hE6, 8'h00);
      host_reset <= 1'b0;
      rd(8'hE6, 8'h00);
   endtask
   // Mirrors, fixed pin bits and readiness tracking
   task automatic t_mirror;
      host.access(1'b0, 10'h202, 8'h3D);
      rd(8'hE1, 8'h3D);
      host.access(1'b0, 10'h206, 8'hFF);
      rd(8'hE3, 8'h7F);
      host.access(1'b0, 10'h204, 8'hFF);
      rd(8'hE2, 8'h2C);
      host.access(1'b0, 10'h204, 8'h00);
      rd(8'hE2, 8'h2C);
      host.access(1'b0, 10'h204, 8'h02);
      rd(8'hE2, 8'h0C);
      readiness_level <= 1'b1;
      @(posedge clock);
      rd(8'hE2, 8'h2E);
      rd(8'hE1, 8'hBD);
   endtask
   // Access mode codes 0 to 6, then the status pin and interrupt view
   task automatic t_mode;
      for (int m = 0; m < 7; m++)
      begin
         host.access(1'b0, 10'h200, 8'(m));
         check({io_mode, floppy_support}, {m > 0 && m < 6, m == 4 || m == 5});
         check({4'h0, access_mode_index}, 8'(m));
      end
      host.access(1'b0, 10'h200, 8'h02);
      host.access(1'b0, 10'h202, 8'h40);
      check({7'h00, status_event_pin_n}, 8'h00);
      ata_irq_request <= 1'b1;
      host_irq_gate_n <= 1'b0;
      rd(8'hE1, 8'hC2);
      host_irq_gate_n <= 1'b1;
      rd(8'hE1, 8'hC0);
      host.access(1'b0, 10'h200, 8'h00);
      check({7'h00, status_event_pin_n}, 8'h01);
   endtask
   // Sticky events, partial clear and group gating
   task automatic t_events;
      ahb(1'b1, 8'hE4, 8'hFF);
      host.access(1'b1, 10'h200, 8'h00);
      rd(8'hE4, 8'h00);
      host.access(1'b1, 10'h1FF, 8'h00);
      host.access(1'b0, 10'h206, 8'h00);
      host.access(1'b0, 10'h204, 8'h00);
      host.access(1'b0, 10'h202, 8'h44);
      host.access(1'b0, 10'h200, 8'h00);
      rd(8'hE4, 8'h3F);
      ahb(1'b1, 8'hE4, 8'h01);
      @(posedge clock); // clear strobe acts one cycle after the data phase
      rd(8'hE4, 8'h3E);
      ahb(1'b1, 8'hE4, 8'h02);
      host.access(1'b0, 10'h202, 8'h44); // set and clear of bit 1 in one cycle
      rd(8'hE4, 8'h3E);
      ahb(1'b1, 8'hE5, 8'h02);
      ahb(1'b1, 8'h53, 8'h04);
      rd(8'hE5, 8'h02);
      rd(8'h52, 8'h04);
      check({7'h00, host_event_active}, 8'h01);
      ahb(1'b1, 8'hE5, 8'h00);
      rd(8'hE4, 8'h3E);
      check({7'h00, host_event_active}, 8'h00);
      rd(8'h52, 8'h00);
   endtask
   // Mid-run reset, strap high: automatic ATA, no false readiness edge
   task automatic t_reset;
      mode_strap_pin <= 1'b1;
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      check({7'h00, status_event_pin_n}, 8'h01);
      rd(8'hE6, 8'h40);
      rd(8'hE2, 8'h0E);
      rd(8'hE4, 8'h00);
      rd(8'hE1, 8'h00);
   endtask
   initial
   begin
      {resetn, hsel, hwrite, htrans, haddr, hwdata, host_reset, ata_irq_request} = '0;
      {readiness_level, mode_strap_pin, host_irq_gate_n, hsize} = {3'b001, 3'b010};
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      t_misc();
      t_mirror();
      t_mode();
      t_events();
      t_reset();
      summarize();
   end
   // Watchdog
   initial
   begin
      repeat (5000) @(posedge clock);
      miscompares++;
      summarize();
   end
endmodule
bind card_config_mirror_and_host_events card_mirror_asserts u_chk (.clock, .resetn, .hsel,
   .htrans, .hwrite, .hready, .host_write, .host_read_attr, .host_addr, .host_wdata,
   .status_event_pin_n, .access_mode_index, .io_mode, .floppy_support,
   .active_interface_flag, .host_event_active);
